// file: hw/bcs_charge_sequencer.v
// charging state machine with safety timers and an axi4-lite register slave
`timescale 1ns/1ps

`include "bcs_consts.vh"

// What this block does
// - shutdown release or power-up: reset state, timers zero, no current, indicators high
// - input-to-battery headroom below dropout returns sequencer to reset from any state except fault
// - battery overvoltage returns sequencer to reset from any state except fault
// - reset goes to prequalification once power, reference and bias are good
// - reset goes straight to fault when power is good and battery is too hot
// - prequalification: tenth current, timer a, constant-current indicator low
// - prequalification to fast charge when above undervoltage and temperature good
// - prequalification timeout before undervoltage cleared leads to fault
// - prequalification with bad temperature suspends charging and freezes timer
// - fast charge: constant current, timer b, constant-current indicator low
// - fast charge to full charge when regulation voltage reached in time
// - fast charge timeout before regulation voltage leads to fault
// - full charge: constant voltage, timer a, constant-voltage indicator low
// - full charge to top-off on low current or timer expiry
// - top-off: constant voltage, indicators high, timer a, then done
// - done: no current, indicators high, back to reset below recharge
// - fast, full or top-off with bad temperature pauses and freezes timers
// - pause: no current, indicators keep previous levels
// - fault: no current, fault indicator low, others high
// - fault is left only through power cycle, shutdown or clearing the software enable
// - shutdown stops charging, high-side switch off, indicators high impedance
// - paused timer resumes from its held value
module bcs_charge_sequencer #(
    parameter [47:0] PREQ_CYCLES = (`BCS_PREQ_TIME_DS * `BCS_CLK_HZ) / `BCS_DS_PER_S,
    parameter [47:0] FAST_CYCLES = (`BCS_FAST_TIME_DS * `BCS_CLK_HZ) / `BCS_DS_PER_S,
    parameter [47:0] FULL_CYCLES = (`BCS_FULL_TIME_DS * `BCS_CLK_HZ) / `BCS_DS_PER_S,
    parameter [47:0] TOP_CYCLES  = (`BCS_TOP_TIME_DS * `BCS_CLK_HZ) / `BCS_DS_PER_S
) (
    // clock, reset, enable
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    // axi4-lite write
    input  wire [3:0]  awaddr,
    input  wire        awvalid,
    output reg         awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // axi4-lite read
    input  wire [3:0]  araddr,
    input  wire        arvalid,
    output reg         arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // sense comparators and pins
    input  wire        shutdown_n,
    input  wire        power_good,
    input  wire        supply_dropout,
    input  wire        battery_overvoltage,
    input  wire        battery_above_undervoltage,
    input  wire        battery_at_regulation,
    input  wire        battery_below_recharge,
    input  wire        temperature_ok,
    input  wire        temperature_hot,
    input  wire        inductor_current_low,
    // charge control
    output reg  [1:0]  charge_mode,
    output reg         high_side_enable,
    // open-drain indicators
    input  wire        constant_current_indicator_n_i,
    output reg         constant_current_indicator_n_o,
    output reg         constant_current_indicator_n_oe,
    input  wire        constant_voltage_indicator_n_i,
    output reg         constant_voltage_indicator_n_o,
    output reg         constant_voltage_indicator_n_oe,
    input  wire        fault_indicator_n_i,
    output reg         fault_indicator_n_o,
    output reg         fault_indicator_n_oe
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    reg  [12:0] sync1_r;
    reg  [12:0] sync2_r;
    wire [12:0] pins_raw;

    assign pins_raw = {fault_indicator_n_i, constant_voltage_indicator_n_i,
                       constant_current_indicator_n_i, inductor_current_low,
                       temperature_hot, temperature_ok, battery_below_recharge,
                       battery_at_regulation, battery_above_undervoltage,
                       battery_overvoltage, supply_dropout, power_good, shutdown_n};

    wire s_shutdown_n_n   = sync2_r[0];
    wire s_pwr      = sync2_r[1];
    wire s_drop     = sync2_r[2];
    wire s_ovp      = sync2_r[3];
    wire s_above_uv = sync2_r[4];
    wire s_at_reg   = sync2_r[5];
    wire s_recharge = sync2_r[6];
    wire s_temp_ok  = sync2_r[7];
    wire s_hot      = sync2_r[8];
    wire s_i_low    = sync2_r[9];

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [2:0]  ret_r;
    reg  [2:0]  ret_nxt;
    reg  [47:0] timer_a_r;
    reg  [47:0] timer_b_r;
    reg         enable_r;
    wire        halt;
    wire        a_done;
    wire        b_done;
    wire        changed;
    reg  [47:0] a_limit;

    // software enable acts like the shutdown pin so a fault can be cleared remotely
    assign halt = !s_shutdown_n_n || !enable_r;

    always @*
    begin
        case (state_r)
            `BCS_ST_PREQUAL: a_limit = PREQ_CYCLES;
            `BCS_ST_FULL:    a_limit = FULL_CYCLES;
            default:         a_limit = TOP_CYCLES;
        endcase
    end

    assign a_done = timer_a_r >= a_limit;
    assign b_done = timer_b_r >= FAST_CYCLES;

    always @*
    begin
        state_nxt = state_r;
        ret_nxt   = ret_r;
        case (state_r)
            `BCS_ST_RESET:
            begin
                if (s_pwr && s_hot)
                    state_nxt = `BCS_ST_FAULT;
                else if (s_pwr)
                    state_nxt = `BCS_ST_PREQUAL;
            end
            `BCS_ST_PREQUAL:
            begin
                if (!s_temp_ok)
                begin
                    state_nxt = `BCS_ST_PAUSE;
                    ret_nxt   = state_r;
                end
                else if (s_above_uv)
                    state_nxt = `BCS_ST_FAST;
                else if (a_done)
                    state_nxt = `BCS_ST_FAULT;
            end
            `BCS_ST_FAST, `BCS_ST_FULL, `BCS_ST_TOPOFF:
            begin
                if (!s_temp_ok)
                begin
                    state_nxt = `BCS_ST_PAUSE;
                    ret_nxt   = state_r;
                end
                else if (state_r == `BCS_ST_FAST && s_at_reg)
                    state_nxt = `BCS_ST_FULL;
                else if (state_r == `BCS_ST_FAST && b_done)
                    state_nxt = `BCS_ST_FAULT;
                else if (state_r == `BCS_ST_FULL && (s_i_low || a_done))
                    state_nxt = `BCS_ST_TOPOFF;
                else if (state_r == `BCS_ST_TOPOFF && a_done)
                    state_nxt = `BCS_ST_DONE;
            end
            `BCS_ST_DONE:
            begin
                if (s_recharge)
                    state_nxt = `BCS_ST_RESET;
            end
            `BCS_ST_PAUSE:
            begin
                if (s_temp_ok)
                    state_nxt = ret_r;
            end
            `BCS_ST_FAULT:
            begin
                state_nxt = `BCS_ST_FAULT;
            end
            default:
                state_nxt = `BCS_ST_RESET;
        endcase
        if (state_r != `BCS_ST_FAULT && (s_drop || s_ovp))
            state_nxt = `BCS_ST_RESET;
        if (halt)
            state_nxt = `BCS_ST_RESET;
    end

    // entering a new phase restarts its timer; pause edges do not
    assign changed = (state_nxt != state_r) && (state_nxt != `BCS_ST_PAUSE)
                     && (state_r != `BCS_ST_PAUSE);

    // ---------------------------------------------------------------
    // sequencer and timer registers
    // ---------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r   <= 13'h0000;
            sync2_r   <= 13'h0000;
            state_r   <= `BCS_ST_RESET;
            ret_r     <= `BCS_ST_RESET;
            timer_a_r <= 48'h0;
            timer_b_r <= 48'h0;
        end
        else if (ce)
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            state_r <= state_nxt;
            ret_r   <= ret_nxt;
            if (state_nxt == `BCS_ST_RESET || changed)
            begin
                timer_a_r <= 48'h0;
                timer_b_r <= 48'h0;
            end
            else if (state_r == `BCS_ST_FAST)
                timer_b_r <= timer_b_r + 48'h1;
            else if (state_r == `BCS_ST_PREQUAL || state_r == `BCS_ST_FULL ||
                     state_r == `BCS_ST_TOPOFF)
                timer_a_r <= timer_a_r + 48'h1;
        end
    end

    // ---------------------------------------------------------------
    // outputs, registered from the next state
    // ---------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            charge_mode                     <= `BCS_MODE_OFF;
            high_side_enable                <= 1'b0;
            constant_current_indicator_n_o  <= 1'b0;
            constant_voltage_indicator_n_o  <= 1'b0;
            fault_indicator_n_o             <= 1'b0;
            constant_current_indicator_n_oe <= 1'b0;
            constant_voltage_indicator_n_oe <= 1'b0;
            fault_indicator_n_oe            <= 1'b0;
        end
        else if (ce)
        begin
            case (state_nxt)
                `BCS_ST_PREQUAL: charge_mode <= `BCS_MODE_TENTH;
                `BCS_ST_FAST:    charge_mode <= `BCS_MODE_CC;
                `BCS_ST_FULL,
                `BCS_ST_TOPOFF:  charge_mode <= `BCS_MODE_CV;
                default:         charge_mode <= `BCS_MODE_OFF;
            endcase
            high_side_enable <= !halt && (state_nxt == `BCS_ST_PREQUAL ||
                                state_nxt == `BCS_ST_FAST || state_nxt == `BCS_ST_FULL ||
                                state_nxt == `BCS_ST_TOPOFF);
            if (halt)
            begin
                constant_current_indicator_n_oe <= 1'b0;
                constant_voltage_indicator_n_oe <= 1'b0;
                fault_indicator_n_oe            <= 1'b0;
            end
            else if (state_nxt != `BCS_ST_PAUSE)
            begin
                constant_current_indicator_n_oe <= state_nxt == `BCS_ST_PREQUAL ||
                                                   state_nxt == `BCS_ST_FAST;
                constant_voltage_indicator_n_oe <= state_nxt == `BCS_ST_FULL;
                fault_indicator_n_oe            <= state_nxt == `BCS_ST_FAULT;
            end
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite slave
    // ---------------------------------------------------------------
    reg        aw_got_r;
    reg        w_got_r;
    reg  [3:0] waddr_r;
    reg [31:0] wdata_r;
    reg  [3:0] wstrb_r;
    reg [31:0] rd_word;
    reg        rd_hit;

    function [31:0] status_word;
        input [2:0]  st;
        input [2:0]  ret;
        input [12:0] pins;
        begin
            status_word = {11'h000, pins, 1'b0, ret, 1'b0, st};
        end
    endfunction

    always @*
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (araddr)
            `BCS_REG_CTRL:    rd_word[`BCS_CTRL_EN_BIT] = enable_r;
            `BCS_REG_STATUS:  rd_word = status_word(state_r, ret_r, sync2_r);
            `BCS_REG_TIMER_A: rd_word = timer_a_r[31:0];
            `BCS_REG_TIMER_B: rd_word = timer_b_r[31:0];
            default:          rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= `BCS_RESP_OKAY;
            arready  <= 1'b0;
            rvalid   <= 1'b0;
            rresp    <= `BCS_RESP_OKAY;
            rdata    <= 32'h0000_0000;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            waddr_r  <= 4'h0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            enable_r <= `BCS_CTRL_RST;
        end
        else if (ce)
        begin
            if (awready && awvalid)
            begin
                awready  <= 1'b0;
                aw_got_r <= 1'b1;
                waddr_r  <= awaddr;
            end
            else if (!aw_got_r && awvalid && !awready && !bvalid)
                awready <= 1'b1;
            if (wready && wvalid)
            begin
                wready  <= 1'b0;
                w_got_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            else if (!w_got_r && wvalid && !wready && !bvalid)
                wready <= 1'b1;
            if (aw_got_r && w_got_r && !bvalid)
            begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= `BCS_RESP_OKAY;
                if (waddr_r == `BCS_REG_CTRL)
                begin
                    if (wstrb_r[0])
                        enable_r <= wdata_r[`BCS_CTRL_EN_BIT];
                end
                else if (waddr_r != `BCS_REG_STATUS && waddr_r != `BCS_REG_TIMER_A &&
                         waddr_r != `BCS_REG_TIMER_B)
                    bresp <= `BCS_RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
            if (arready && arvalid)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_word;
                rresp   <= rd_hit ? `BCS_RESP_OKAY : `BCS_RESP_SLVERR;
            end
            else if (arvalid && !arready && !rvalid)
                arready <= 1'b1;
            if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

endmodule // bcs_charge_sequencer

// file: hw/bcs_consts.vh
// constants for the battery charge sequencer
`ifndef BCS_CONSTS_VH
`define BCS_CONSTS_VH

// ---------------------------------------------------------------
// sequencer states
// ---------------------------------------------------------------
`define BCS_ST_RESET    3'h0
`define BCS_ST_PREQUAL  3'h1
`define BCS_ST_FAST     3'h2
`define BCS_ST_FULL     3'h3
`define BCS_ST_TOPOFF   3'h4
`define BCS_ST_DONE     3'h5
`define BCS_ST_PAUSE    3'h6
`define BCS_ST_FAULT    3'h7

// ---------------------------------------------------------------
// charge mode codes
// ---------------------------------------------------------------
`define BCS_MODE_OFF    2'h0
`define BCS_MODE_TENTH  2'h1
`define BCS_MODE_CC     2'h2
`define BCS_MODE_CV     2'h3

// ---------------------------------------------------------------
// timing, times in deciseconds
// ---------------------------------------------------------------
`define BCS_CLK_HZ       48'h0000_05f5_e100
`define BCS_DS_PER_S     48'h0000_0000_000a
`define BCS_PREQ_TIME_DS 48'h0000_0000_1194
`define BCS_FAST_TIME_DS 48'h0000_0000_d2f0
`define BCS_FULL_TIME_DS 48'h0000_0000_d2f0
`define BCS_TOP_TIME_DS  48'h0000_0000_6978

// ---------------------------------------------------------------
// register map and fields
// ---------------------------------------------------------------
`define BCS_REG_CTRL     4'h0
`define BCS_REG_STATUS   4'h4
`define BCS_REG_TIMER_A  4'h8
`define BCS_REG_TIMER_B  4'hc
`define BCS_CTRL_EN_BIT  0
`define BCS_CTRL_RST     1'h1
`define BCS_STAT_ST_LSB  0
`define BCS_STAT_RET_LSB 4
`define BCS_STAT_IN_LSB  8
`define BCS_RESP_OKAY    2'h0
`define BCS_RESP_SLVERR  2'h2

`endif

// file: verification/bcs_charge_sequencer_test.sv
// self-checking bench for the charge sequencer
`timescale 1ns/1ps
`include "bcs_consts.vh"
module bcs_charge_sequencer_test;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, shutdown_n = 1'h1, power_good = 1'h0;
    logic supply_dropout = 1'h0, battery_overvoltage = 1'h0, battery_above_undervoltage = 1'h0;
    logic battery_at_regulation = 1'h0, battery_below_recharge = 1'h0, temperature_ok = 1'h1;
    logic temperature_hot = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rd_w, t1, t2;
    logic [1:0] rsp;
    wire awready, wready, bvalid, arready, rvalid, high_side_enable, inductor_current_low;
    wire cc_oe, cv_oe, flt_oe, cc_pin_n, cv_pin_n, flt_pin_n;
    wire [1:0] bresp, rresp, charge_mode;
    wire [31:0] rdata;
    int err_count = 0, checks = 0;
    always #5 aclk = ~aclk;
    // short phase counts keep the run brief
    bcs_charge_sequencer #(.PREQ_CYCLES(48'h3c), .FAST_CYCLES(48'h50), .FULL_CYCLES(48'h3c),
        .TOP_CYCLES(48'h1e)) bcs_charge_sequencer_i (
        .aclk, .aresetn, .ce(1'h1), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .shutdown_n, .power_good, .supply_dropout, .battery_overvoltage,
        .battery_above_undervoltage, .battery_at_regulation, .battery_below_recharge,
        .temperature_ok, .temperature_hot, .inductor_current_low, .charge_mode,
        .high_side_enable, .constant_current_indicator_n_i(cc_pin_n),
        .constant_current_indicator_n_o(), .constant_current_indicator_n_oe(cc_oe),
        .constant_voltage_indicator_n_i(cv_pin_n), .constant_voltage_indicator_n_o(),
        .constant_voltage_indicator_n_oe(cv_oe), .fault_indicator_n_i(flt_pin_n),
        .fault_indicator_n_o(), .fault_indicator_n_oe(flt_oe));
    bcs_charger_model bcs_charger_model_i (.aclk, .charge_mode, .cc_oe, .cv_oe,
        .fault_oe(flt_oe), .cc_pin_n, .cv_pin_n, .fault_pin_n(flt_pin_n),
        .current_low(inductor_current_low));
    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 200)
        begin
            chk(32'h0, 32'h1);
            complete_run;
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        while (!bvalid && n < 200);
        hang(n);
        rsp = bresp;
        bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'h0;
        end
        while (!rvalid && n < 200);
        hang(n);
        rd_w = rdata;
        rsp = rresp;
        rready <= 1'h0;
    endtask
    // polls the state field; a state never reached counts as a mismatch
    task automatic expect_state(input logic [2:0] s);
        int n;
        n = 0;
        do
        begin
            axi_rd(`BCS_REG_STATUS);
            n++;
        end
        while (rd_w[2:0] !== s && n < 80);
        chk({29'h0, rd_w[2:0]}, {29'h0, s});
    endtask
    // mode and the three pull-down enables, cc cv fault
    task automatic outs(input logic [4:0] e);
        #1;
        chk({27'h0, charge_mode, cc_oe, cv_oe, flt_oe}, {27'h0, e});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        outs(5'h00);
        axi_rd(`BCS_REG_CTRL);
        chk(rd_w, 32'h1);
        axi_rd(4'h2);
        chk({rd_w[29:0], rsp}, {30'h0, `BCS_RESP_SLVERR});
        axi_wr(4'h2, 32'h0);
        chk({30'h0, rsp}, {30'h0, `BCS_RESP_SLVERR});
        axi_wr(`BCS_REG_STATUS, 32'hffff_ffff);
        chk({30'h0, rsp}, {30'h0, `BCS_RESP_OKAY});
        expect_state(`BCS_ST_RESET);
        $display("test regs ended");
    endtask
    task automatic t_charge;
        power_good <= 1'h1;
        expect_state(`BCS_ST_PREQUAL);
        outs(5'h0c);
        temperature_ok <= 1'h0;
        expect_state(`BCS_ST_PAUSE);
        outs(5'h04);
        axi_rd(`BCS_REG_TIMER_A);
        t1 = rd_w;
        repeat (6) @(posedge aclk);
        axi_rd(`BCS_REG_TIMER_A);
        chk(rd_w, t1);
        temperature_ok <= 1'h1;
        expect_state(`BCS_ST_PREQUAL);
        axi_rd(`BCS_REG_TIMER_A);
        chk({31'h0, rd_w > t1}, 32'h1);
        battery_above_undervoltage <= 1'h1;
        expect_state(`BCS_ST_FAST);
        outs(5'h14);
        battery_at_regulation <= 1'h1;
        expect_state(`BCS_ST_FULL);
        outs(5'h1a);
        expect_state(`BCS_ST_TOPOFF);
        outs(5'h18);
        expect_state(`BCS_ST_DONE);
        outs(5'h00);
        battery_at_regulation <= 1'h0;
        battery_above_undervoltage <= 1'h0;
        battery_below_recharge <= 1'h1;
        expect_state(`BCS_ST_PREQUAL);
        battery_below_recharge <= 1'h0;
        axi_wr(`BCS_REG_CTRL, 32'h0);
        expect_state(`BCS_ST_RESET);
        outs(5'h00);
        axi_wr(`BCS_REG_CTRL, 32'h1);
        $display("test charge ended");
    endtask
    task automatic t_pause;
        battery_above_undervoltage <= 1'h1;
        expect_state(`BCS_ST_FAST);
        temperature_ok <= 1'h0;
        expect_state(`BCS_ST_PAUSE);
        outs(5'h04);
        chk({29'h0, rd_w[6:4]}, {29'h0, `BCS_ST_FAST});
        axi_rd(`BCS_REG_TIMER_B);
        t2 = rd_w;
        repeat (6) @(posedge aclk);
        axi_rd(`BCS_REG_TIMER_B);
        chk(rd_w, t2);
        temperature_ok <= 1'h1;
        expect_state(`BCS_ST_FAST);
        supply_dropout <= 1'h1;
        expect_state(`BCS_ST_RESET);
        supply_dropout <= 1'h0;
        expect_state(`BCS_ST_FAST);
        battery_overvoltage <= 1'h1;
        expect_state(`BCS_ST_RESET);
        battery_overvoltage <= 1'h0;
        $display("test pause ended");
    endtask
    task automatic t_fault;
        expect_state(`BCS_ST_FAULT);
        outs(5'h01);
        supply_dropout <= 1'h1;
        repeat (8) @(posedge aclk);
        expect_state(`BCS_ST_FAULT);
        supply_dropout <= 1'h0;
        shutdown_n <= 1'h0;
        repeat (5) @(posedge aclk);
        outs(5'h00);
        chk({31'h0, high_side_enable}, 32'h0);
        battery_above_undervoltage <= 1'h0;
        shutdown_n <= 1'h1;
        expect_state(`BCS_ST_PREQUAL);
        expect_state(`BCS_ST_FAULT);
        shutdown_n <= 1'h0;
        temperature_hot <= 1'h1;
        repeat (5) @(posedge aclk);
        shutdown_n <= 1'h1;
        expect_state(`BCS_ST_FAULT);
        $display("test fault ended");
    endtask
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        t_regs;
        t_charge;
        t_pause;
        t_fault;
        complete_run;
    end
endmodule // bcs_charge_sequencer_test

// file: verification/bcs_charger_model.sv
// far-side model: indicator pull-ups and battery current taper
`timescale 1ns/1ps
`include "bcs_consts.vh"
module bcs_charger_model #(
    parameter int TAPER = 12
) (
    // clock
    input  wire logic       aclk,
    // from the sequencer
    input  wire logic [1:0] charge_mode,
    input  wire logic       cc_oe,
    input  wire logic       cv_oe,
    input  wire logic       fault_oe,
    // pin levels and current sense
    output wire logic       cc_pin_n,
    output wire logic       cv_pin_n,
    output wire logic       fault_pin_n,
    output wire logic       current_low
);
    int cv_cycles = 0;
    // open-drain pins
    // a released pin shows the pull-up level, never the last driven one
    assign cc_pin_n    = cc_oe ? 1'h0 : 1'h1;
    assign cv_pin_n    = cv_oe ? 1'h0 : 1'h1;
    assign fault_pin_n = fault_oe ? 1'h0 : 1'h1;
    // current taper
    // current falls only after a stretch of constant voltage, as a real cell does
    always @(posedge aclk)
    begin
        if (charge_mode == `BCS_MODE_CV)
            cv_cycles <= cv_cycles + 1;
        else
            cv_cycles <= 0;
    end
    assign current_low = cv_cycles >= TAPER;
endmodule // bcs_charger_model

// file: verification/bcs_seq_monitor.sv
// assertions watching the charge sequencer ports
`timescale 1ns/1ps
`include "bcs_consts.vh"
module bcs_seq_monitor (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // sense pins
    input wire logic        shutdown_n,
    input wire logic        supply_dropout,
    input wire logic        battery_overvoltage,
    // charge control and indicators
    input wire logic [1:0]  charge_mode,
    input wire logic        high_side_enable,
    input wire logic        constant_current_indicator_n_oe,
    input wire logic        constant_voltage_indicator_n_oe,
    input wire logic        fault_indicator_n_oe
);
    wire [2:0] oe_w  = {constant_current_indicator_n_oe, constant_voltage_indicator_n_oe,
                        fault_indicator_n_oe};
    wire       off_w = charge_mode == `BCS_MODE_OFF;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // pins cross two sync flops, so four samples cover the reaction
    sequence halt_s;
        !shutdown_n [*4];
    endsequence
    sequence drop_s;
        supply_dropout [*4];
    endsequence
    sequence ovp_s;
        battery_overvoltage [*4];
    endsequence
    sequence run_s;
        shutdown_n [*4] ##0 fault_indicator_n_oe;
    endsequence
    shutdown_off_a:
        assert property (halt_s |-> off_w && !high_side_enable && oe_w == 3'h0)
            else $error("shutdown left charging or an indicator on");
    dropout_reset_a:
        assert property (drop_s |-> off_w && oe_w[2:1] == 2'h0)
            else $error("dropout did not stop charging");
    overvolt_reset_a:
        assert property (ovp_s |-> off_w && oe_w[2:1] == 2'h0)
            else $error("overvoltage did not stop charging");
    fault_out_a:
        assert property (fault_indicator_n_oe |-> off_w && oe_w[2:1] == 2'h0)
            else $error("fault indicator with charge or other indicator");
    tenth_out_a:
        assert property (charge_mode == `BCS_MODE_TENTH |-> oe_w == 3'h4)
            else $error("tenth current with wrong indicators");
    fast_out_a:
        assert property (charge_mode == `BCS_MODE_CC |-> oe_w == 3'h4)
            else $error("constant current with wrong indicators");
    full_out_a:
        assert property ($rose(constant_voltage_indicator_n_oe)
            |-> charge_mode == `BCS_MODE_CV && oe_w == 3'h2)
            else $error("full indicator without constant voltage");
    fault_sticky_a:
        assert property (run_s |=> fault_indicator_n_oe)
            else $error("fault left without shutdown");
    pause_keep_a:
        assert property ($past(charge_mode) == `BCS_MODE_CC && off_w && !fault_indicator_n_oe
            && !$past(supply_dropout, 3) && !$past(battery_overvoltage, 3)
            && $past(shutdown_n, 3) |-> constant_current_indicator_n_oe)
            else $error("pause changed the fast indicator");
endmodule // bcs_seq_monitor

bind bcs_charge_sequencer bcs_seq_monitor bcs_seq_monitor_i (
    .aclk, .aresetn, .shutdown_n, .supply_dropout, .battery_overvoltage, .charge_mode,
    .high_side_enable, .constant_current_indicator_n_oe, .constant_voltage_indicator_n_oe,
    .fault_indicator_n_oe
);
